// [src/dtm_pkg.sv]
// Constants and types shared by the dual timer mode control block
package dtm_pkg;
	localparam int ADDR_W = 12;
	// Register indices; the byte address is four times the index
	localparam logic [9:0] IDX_RUN_CTRL = 10'h0088;
	localparam logic [9:0] IDX_MODE     = 10'h0089;
	localparam logic [9:0] IDX_TL0      = 10'h008A;
	localparam logic [9:0] IDX_TL1      = 10'h008B;
	localparam logic [9:0] IDX_TH0      = 10'h008C;
	localparam logic [9:0] IDX_TH1      = 10'h008D;
	localparam logic [9:0] IDX_CLK_CTRL = 10'h008E;
	localparam logic [9:0] IDX_EXT_CFG  = 10'h00E4;
	// Reset values
	localparam logic [7:0] MODE_RST     = 8'h00;
	localparam logic [7:0] CLK_CTRL_RST = 8'h00;
	localparam logic [7:0] EXT_CFG_RST  = 8'h00;
	localparam logic [7:0] RUN_CTRL_RST = 8'h00;
	// Run control field positions
	localparam int RUN_ZERO_BIT = 0;
	localparam int RUN_ONE_BIT  = 1;
	localparam int OVF_ZERO_BIT = 4;
	localparam int OVF_ONE_BIT  = 5;
	// Clock control field positions
	localparam int PRESC_LSB  = 0;
	localparam int CLK_ZERO_BIT = 3;
	localparam int CLK_ONE_BIT  = 4;
	// External interrupt configuration field positions
	localparam int POL0_BIT   = 0;
	localparam int POL1_BIT   = 1;
	// Prescaler divisors
	localparam logic [3:0] DIV12_LAST = 4'h000B;
	localparam logic [1:0] DIV4_LAST  = 2'h3;
	localparam logic [2:0] DIV8_LAST  = 3'h7;
	// Prescale codes
	localparam logic [1:0] PRESC_DIV12 = 2'h0;
	localparam logic [1:0] PRESC_DIV48 = 2'h2;
	localparam logic [1:0] PRESC_EXT8  = 2'h3;
	// Timer modes
	localparam logic [1:0] MODE_13BIT  = 2'h0;
	localparam logic [1:0] MODE_16BIT  = 2'h1;
	localparam logic [1:0] MODE_8RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT  = 2'h3;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic       timer_one_gate_enable;
		logic       timer_one_count_select;
		logic [1:0] timer_one_mode_field;
		logic       timer_zero_gate_enable;
		logic       timer_zero_count_select;
		logic [1:0] timer_zero_mode_field;
	} dtm_mode_t;

	typedef struct packed {
		logic       ovf;
		logic [7:0] hi;
		logic [7:0] lo;
	} dtm_count_t;
endpackage

// [src/dtm_top.sv]
// Dual timer/counter with mode control and an AXI4-Lite register slave
//
// Notes on behaviour
// RL1: Gate off: timer one runs when run set.
// RL2: Gate on: timer one also needs active interrupt-one.
// RL3: Timer mode: timer one counts selected timebase.
// RL4: Counter mode: timer one counts count-pin falls.
// RL5: Timer one modes 13, 16, 8-reload, inactive.
// RL6: Gate off: timer zero runs when run set.
// RL7: Gate on: timer zero also needs active interrupt-zero.
// RL8: Timer mode: timer zero counts selected timebase.
// RL9: Counter mode: timer zero counts count-pin falls.
// RL10: Timer zero modes 13, 16, 8-reload, split.
// RL11: Clock select and prescale choose timebase.
// RL12: Count pins synchronised, falls detected, one step.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dtm_top
	import dtm_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              timer_zero_count_pin,
	input  wire logic              timer_one_count_pin,
	input  wire logic              ext_interrupt_zero_input,
	input  wire logic              ext_interrupt_one_input,
	input  wire logic              external_osc_clock,
	output logic                   timer_zero_overflow,
	output logic                   timer_one_overflow
);
	function automatic dtm_count_t dtm_step(input logic [1:0] mode, input dtm_count_t c);
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0]  s8;
		dtm_count_t  r;
		s13 = {1'b0, c.hi, c.lo[4:0]} + 14'h0001;
		s16 = {1'b0, c.hi, c.lo} + 17'h0_0001;
		s8  = {1'b0, c.lo} + 9'h001;
		r   = c;
		r.ovf = 1'b0;
		case (mode)
			MODE_13BIT: r = {s13[13], s13[12:5], c.lo[7:5], s13[4:0]};
			MODE_16BIT: r = s16;
			MODE_8RELOAD: r = {s8[8], c.hi, (s8[8] ? c.hi : s8[7:0])};
			default: r = {1'b0, c.hi, c.lo};
		endcase
		return r;
	endfunction

	// Registers
	dtm_mode_t  mode_q;
	logic [7:0] clk_ctrl_q;
	logic [7:0] ext_cfg_q;
	logic       run0_q, run1_q, ovf0_q, ovf1_q;
	dtm_count_t t0_q, t1_q;
	dtm_count_t t0_d, t1_d;
	logic       ovf0_set, ovf1_set;

	// Pin synchronisers and edge history
	logic [1:0] cnt0_sync_q, cnt1_sync_q, ext0_sync_q, ext1_sync_q, osc_sync_q;
	logic       cnt0_prev_q, cnt1_prev_q, osc_prev_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt0_sync_q <= 2'h3;
			cnt1_sync_q <= 2'h3;
			ext0_sync_q <= 2'h3;
			ext1_sync_q <= 2'h3;
			osc_sync_q  <= 2'h0;
			cnt0_prev_q <= 1'b1;
			cnt1_prev_q <= 1'b1;
			osc_prev_q  <= 1'b0;
		end else begin
			cnt0_sync_q <= {cnt0_sync_q[0], timer_zero_count_pin};  // see RL12
			cnt1_sync_q <= {cnt1_sync_q[0], timer_one_count_pin};  // see RL12
			ext0_sync_q <= {ext0_sync_q[0], ext_interrupt_zero_input};
			ext1_sync_q <= {ext1_sync_q[0], ext_interrupt_one_input};
			osc_sync_q  <= {osc_sync_q[0], external_osc_clock};
			cnt0_prev_q <= cnt0_sync_q[1];
			cnt1_prev_q <= cnt1_sync_q[1];
			osc_prev_q  <= osc_sync_q[1];
		end
	end

	wire fall0 = cnt0_prev_q & ~cnt0_sync_q[1];  // see RL12
	wire fall1 = cnt1_prev_q & ~cnt1_sync_q[1];  // see RL12
	wire osc_rise = osc_sync_q[1] & ~osc_prev_q;

	// Prescaler: divide by 12, by 48, and external oscillator by 8
	logic [3:0] div12_q;
	logic [1:0] div4_q;
	logic [2:0] div8_q;
	wire tick12 = (div12_q == DIV12_LAST);
	wire tick48 = tick12 && (div4_q == DIV4_LAST);
	wire tick8  = osc_rise && (div8_q == DIV8_LAST);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div12_q <= 4'h0;
			div4_q  <= 2'h0;
			div8_q  <= 3'h0;
		end else begin
			div12_q <= tick12 ? 4'h0 : div12_q + 4'h1;
			div4_q  <= tick12 ? div4_q + 2'h1 : div4_q;
			div8_q  <= osc_rise ? div8_q + 3'h1 : div8_q;
		end
	end

	wire [1:0] presc = clk_ctrl_q[PRESC_LSB +: 2];
	// Code 01 has no defined source and falls back to divide by 12
	wire presc_tick = (presc == PRESC_DIV48) ? tick48 :
	                  (presc == PRESC_EXT8)  ? tick8  : tick12;  // see RL11
	wire tb0 = clk_ctrl_q[CLK_ZERO_BIT] | presc_tick;  // see RL11
	wire tb1 = clk_ctrl_q[CLK_ONE_BIT] | presc_tick;   // see RL11

	// Gate: polarity bit 0 means the input is active low
	wire ext0_act = ext0_sync_q[1] ~^ ext_cfg_q[POL0_BIT];
	wire ext1_act = ext1_sync_q[1] ~^ ext_cfg_q[POL1_BIT];
	wire en0 = run0_q & (~mode_q.timer_zero_gate_enable | ext0_act);  // see RL6, RL7
	wire en1 = run1_q & (~mode_q.timer_one_gate_enable | ext1_act);   // see RL1, RL2

	wire src0 = mode_q.timer_zero_count_select ? fall0 : tb0;  // see RL8, RL9
	wire src1 = mode_q.timer_one_count_select ? fall1 : tb1;   // see RL3, RL4
	wire inc0 = en0 & src0;
	wire inc1 = en1 & src1;
	wire split = (mode_q.timer_zero_mode_field == MODE_SPLIT);
	// In split mode the high half of timer zero runs on timer one's run bit
	wire inc0_hi = split & run1_q & tb0;

	dtm_count_t t0_step, t1_step;
	logic [8:0] t0_lo_s, t0_hi_s;
	always_comb begin
		t0_step = dtm_step(mode_q.timer_zero_mode_field, t0_q);  // see RL10
		t1_step = dtm_step(mode_q.timer_one_mode_field, t1_q);   // see RL5
		t0_lo_s = {1'b0, t0_q.lo} + 9'h001;
		t0_hi_s = {1'b0, t0_q.hi} + 9'h001;
		t0_d = t0_q;
		t1_d = t1_q;
		ovf0_set = 1'b0;
		ovf1_set = 1'b0;
		if (split) begin
			if (inc0) begin
				t0_d.lo = t0_lo_s[7:0];  // see RL10
				ovf0_set = t0_lo_s[8];
			end
			if (inc0_hi) begin
				t0_d.hi = t0_hi_s[7:0];  // see RL10
				ovf1_set = t0_hi_s[8];
			end
		end else if (inc0) begin
			t0_d = {1'b0, t0_step.hi, t0_step.lo};
			ovf0_set = t0_step.ovf;
		end
		if (inc1 && mode_q.timer_one_mode_field != MODE_SPLIT) begin  // see RL5
			t1_d = {1'b0, t1_step.hi, t1_step.lo};
			ovf1_set = ovf1_set | t1_step.ovf;
		end
	end

	// AXI4-Lite write path: address and data latched separately
	logic              aw_full_q, w_full_q, bvalid_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0]        wbyte_q;
	logic              wlane_q;
	logic [1:0]        bresp_q;
	wire [9:0] widx = awaddr_q[ADDR_W-1:2];
	wire do_wr = aw_full_q & w_full_q & ~bvalid_q;
	wire wr_en = do_wr & wlane_q;
	wire w_hit = (widx == IDX_RUN_CTRL) || (widx == IDX_MODE) || (widx == IDX_TL0) ||
	             (widx == IDX_TL1) || (widx == IDX_TH0) || (widx == IDX_TH1) ||
	             (widx == IDX_CLK_CTRL) || (widx == IDX_EXT_CFG);
	wire wr_run = wr_en && widx == IDX_RUN_CTRL;

	assign s_axi_awready = ~aw_full_q & ~bvalid_q;
	assign s_axi_wready  = ~w_full_q & ~bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			awaddr_q  <= '0;
			wbyte_q   <= 8'h00;
			wlane_q   <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				wbyte_q  <= s_axi_wdata[7:0];
				wlane_q  <= s_axi_wstrb[0];
			end
			if (do_wr) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= w_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Register file and counters; a software write wins over a count step
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q     <= MODE_RST;
			clk_ctrl_q <= CLK_CTRL_RST;
			ext_cfg_q  <= EXT_CFG_RST;
			run0_q     <= RUN_CTRL_RST[RUN_ZERO_BIT];
			run1_q     <= RUN_CTRL_RST[RUN_ONE_BIT];
			ovf0_q     <= RUN_CTRL_RST[OVF_ZERO_BIT];
			ovf1_q     <= RUN_CTRL_RST[OVF_ONE_BIT];
			t0_q       <= '0;
			t1_q       <= '0;
			timer_zero_overflow <= 1'b0;
			timer_one_overflow  <= 1'b0;
		end else begin
			t0_q <= t0_d;
			t1_q <= t1_d;
			timer_zero_overflow <= ovf0_set;
			timer_one_overflow  <= ovf1_set;
			// Flags clear on a one written, but a fresh overflow wins
			ovf0_q <= ovf0_set | (ovf0_q & ~(wr_run & wbyte_q[OVF_ZERO_BIT]));
			ovf1_q <= ovf1_set | (ovf1_q & ~(wr_run & wbyte_q[OVF_ONE_BIT]));
			if (wr_run) begin
				run0_q <= wbyte_q[RUN_ZERO_BIT];
				run1_q <= wbyte_q[RUN_ONE_BIT];
			end
			if (wr_en && widx == IDX_MODE)
				mode_q <= wbyte_q;
			if (wr_en && widx == IDX_CLK_CTRL)
				clk_ctrl_q <= wbyte_q;
			if (wr_en && widx == IDX_EXT_CFG)
				ext_cfg_q <= wbyte_q;
			if (wr_en && widx == IDX_TL0)
				t0_q.lo <= wbyte_q;
			if (wr_en && widx == IDX_TH0)
				t0_q.hi <= wbyte_q;
			if (wr_en && widx == IDX_TL1)
				t1_q.lo <= wbyte_q;
			if (wr_en && widx == IDX_TH1)
				t1_q.hi <= wbyte_q;
		end
	end

	// AXI4-Lite read path
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	wire [9:0] ridx = s_axi_araddr[ADDR_W-1:2];
	wire [7:0] run_view = {2'b00, ovf1_q, ovf0_q, 2'b00, run1_q, run0_q};
	wire r_hit = (ridx == IDX_RUN_CTRL) || (ridx == IDX_MODE) || (ridx == IDX_TL0) ||
	             (ridx == IDX_TL1) || (ridx == IDX_TH0) || (ridx == IDX_TH1) ||
	             (ridx == IDX_CLK_CTRL) || (ridx == IDX_EXT_CFG);
	wire [7:0] rbyte = (ridx == IDX_RUN_CTRL) ? run_view :
	                   (ridx == IDX_MODE)     ? mode_q :
	                   (ridx == IDX_TL0)      ? t0_q.lo :
	                   (ridx == IDX_TH0)      ? t0_q.hi :
	                   (ridx == IDX_TL1)      ? t1_q.lo :
	                   (ridx == IDX_TH1)      ? t1_q.hi :
	                   (ridx == IDX_CLK_CTRL) ? clk_ctrl_q :
	                   (ridx == IDX_EXT_CFG)  ? ext_cfg_q : 8'h00;

	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= {24'h00_0000, rbyte};
			rresp_q  <= r_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [tb/dtm_chk.sv]
// Bus handshake checks for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module dtm_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_rd;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	a_rd_answer: assert property (s_rd |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
	a_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not released");
	a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while busy");
	a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	a_wr_answer: assert property (s_wr |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write not answered two cycles after address and data");
	a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer not held");
	a_wr_done: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
		else $error("write channels not reopened");
	a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
endmodule
bind dtm_top dtm_chk chk_u (.*);
`default_nettype wire

// [tb/dtm_pins.sv]
// Count, gate and slow oscillator pins facing the timer block
`timescale 1ns/1ps
`default_nettype none
module dtm_pins (
	input  wire logic aclk,
	output logic      timer_zero_count_pin,
	output logic      timer_one_count_pin,
	output logic      ext_interrupt_zero_input,
	output logic      ext_interrupt_one_input,
	output logic      external_osc_clock
);
	initial begin
		timer_zero_count_pin = 1'h1;
		timer_one_count_pin = 1'h1;
		ext_interrupt_zero_input = 1'h1;
		ext_interrupt_one_input = 1'h1;
		external_osc_clock = 1'h0;
		#7;
		forever #30 external_osc_clock = !external_osc_clock;
	end
	// One falling edge: three cycles low, three high
	task automatic fall(input logic t);
		if (t) timer_one_count_pin <= 1'h0;
		else timer_zero_count_pin <= 1'h0;
		repeat (3) @(posedge aclk);
		timer_one_count_pin <= 1'h1;
		timer_zero_count_pin <= 1'h1;
		repeat (3) @(posedge aclk);
	endtask
endmodule
`default_nettype wire

// [tb/tb_dual_timer_mode_control.sv]
// Self-checking bench for the dual timer block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("FAIL %0t got %0h", $time, g); end end
module tb_dual_timer_mode_control;
	import dtm_pkg::*;
	logic              aclk = 1'h0, aresetn = 1'h0, sel = 1'h0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]        s_axi_wstrb = 4'hf;
	logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic              s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              timer_zero_count_pin, timer_one_count_pin, external_osc_clock;
	logic              ext_interrupt_zero_input, ext_interrupt_one_input;
	logic              timer_zero_overflow, timer_one_overflow;
	int                errors = 0, checks = 0, cyc = 0, gap = 0, r, n[7], ex[7];
	logic [7:0]        md[7] = '{8'h05, 8'h0d, 8'h0d, 8'hd0, 8'hd0, 8'hf0, 8'h50};
	logic [7:0]        gk[7] = '{8'h08, 8'h00, 8'h02, 8'h03, 8'h08, 8'h10, 8'h08};
	logic [7:0]        gm[7] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 8'h20, 8'h03};
	int                gp[7] = '{16, 192, 768, 384, 8192, 16, 256};
	logic [6:0]        lv = 7'h4c, gs = 7'h60;
	logic [33:0]       rq[$];
	logic [1:0]        bq[$];
	int                pq[$];
	dtm_top dut_u (.*);
	dtm_pins pm (.*);
	always #10 aclk = !aclk;
	// Result watcher: oldest note against each answer or overflow gap
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			errors++;
			$display("FAIL %0t timeout", $time);
			test_done();
		end
		if (s_axi_rvalid && s_axi_rready) `CHK({s_axi_rresp, s_axi_rdata}, rq.pop_front())
		if (s_axi_bvalid && s_axi_bready) `CHK(s_axi_bresp, bq.pop_front())
		if (sel ? timer_one_overflow : timer_zero_overflow) begin
			if (pq.size() > 0) `CHK(gap, pq.pop_front())
			gap <= 1;
		end else begin
			gap <= gap + 1;
		end
	end
	task automatic wr(input logic [9:0] idx, input logic [7:0] v, input logic [1:0] e);
		logic a, w;
		bq.push_back(e);
		a = 1'h1;
		w = 1'h1;
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h00_0000, v};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (a || w) begin
			@(posedge aclk);
			if (s_axi_awready) a = 1'h0;
			if (s_axi_wready) w = 1'h0;
			s_axi_awvalid <= a;
			s_axi_wvalid <= w;
		end
		s_axi_bready <= 1'h1;
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [9:0] idx, input logic [7:0] v, input logic [1:0] e);
		rq.push_back({e, 24'h00_0000, v});
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
	endtask
	task automatic test_done();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		r = $urandom(32'hd67c_3a06);
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(IDX_MODE, MODE_RST, RESP_OKAY);
		wr(10'h010, 8'hff, RESP_SLVERR);
		rd(10'h010, 8'h00, RESP_SLVERR);
		r = $urandom;
		wr(IDX_MODE, r[7:0], RESP_OKAY);
		rd(IDX_MODE, r[7:0], RESP_OKAY);
		wr(IDX_EXT_CFG, 8'h01, RESP_OKAY);
		// Counting mode in place before timer zero starts
		wr(IDX_MODE, md[0], RESP_OKAY);
		wr(IDX_RUN_CTRL, 8'h01, RESP_OKAY);
		r = $urandom_range(7, 1);
		n = '{r, 3, 2, 3, 2, 2, 1};
		ex = '{r, r, r + 2, 0, 2, 2, 3};
		// Pin counting under each gate and polarity choice, in 16-bit mode and timer one's inactive mode
		for (int i = 0; i < 7; i++) begin
			wr(IDX_MODE, md[i], RESP_OKAY);
			if (i == 3) wr(IDX_RUN_CTRL, 8'h02, RESP_OKAY);
			if (i < 3) pm.ext_interrupt_zero_input <= lv[i];
			else pm.ext_interrupt_one_input <= lv[i];
			repeat (n[i]) pm.fall(i > 2);
			rd(i > 2 ? IDX_TL1 : IDX_TL0, ex[i][7:0], RESP_OKAY);
		end
		wr(IDX_RUN_CTRL, 8'h03, RESP_OKAY);
		// Overflow spacing for each timebase, in 8-reload, 13-bit and split modes
		for (int i = 0; i < 7; i++) begin
			sel <= gs[i];
			wr(IDX_CLK_CTRL, gk[i], RESP_OKAY);
			wr(IDX_MODE, gm[i], RESP_OKAY);
			// Reload value set after the mode, as a running high byte drifts
			wr(gs[i] ? IDX_TH1 : IDX_TH0, 8'hf0, RESP_OKAY);
			@(posedge aclk iff (sel ? timer_one_overflow : timer_zero_overflow));
			#1 pq.push_back(gp[i]);
			@(posedge aclk iff (sel ? timer_one_overflow : timer_zero_overflow));
			#1;
		end
		// Overflow flags: stop both timers, read, clear by ones
		wr(IDX_RUN_CTRL, 8'h00, RESP_OKAY);
		rd(IDX_RUN_CTRL, 8'h30, RESP_OKAY);
		wr(IDX_RUN_CTRL, 8'h30, RESP_OKAY);
		rd(IDX_RUN_CTRL, 8'h00, RESP_OKAY);
		test_done();
	end
endmodule
`default_nettype wire
